// *** gpibpp_dev_end.sv ***
`timescale 1ns/1ns
// Functional notes
// - Bus active only if strap reads 4
// - Listen address with remote enable: go remote
// - Controller marks last message character with EOI
// - Semicolons split commands, delivered in order
// - Text reply ends with CR LF
// - Remote enable released: back to local
// - Plot bytes only when addressed to talk
// - Controller sends dump command, then addresses talker
// - EOI on final plot byte
// - Plot output capped at 50 kilobytes
// - Controller ends plot with UNT, UNL, local
// - Controller sends listen address, PPC, enable byte
// - Enable byte is 0110, sense, line field
// - Line field is data line minus one
// - Drive poll line when sense equals request
// - Disable byte 0111 stops poll response
// - Addressed PPU clears poll configuration
// - UNT and UNL after configuration optional
module gpibpp_dev_end #(
    parameter int PLOT_LIMIT = gpibpp_pkg::PLOT_MAX     // Largest plot in bytes
) (
    input  wire logic       clk,            // 100 MHz clock
    input  wire logic       srst,           // Synchronous reset
    gpibpp_bus_if.dev       bus,            // Bus towards controller
    input  wire logic [4:0] addrSwitch,     // Rear address selector
    input  wire logic       srq,            // Service request state
    output logic [7:0]      cmdByte,        // Received message character
    output logic            cmdValid,       // Character pulse
    output logic            cmdEnd,         // End of one command pulse
    input  wire logic [7:0] txData,         // Reply or plot byte
    input  wire logic       txValid,        // Byte offered
    input  wire logic       txLast,         // Last byte of reply or plot
    input  wire logic       txPlot,         // Byte belongs to plot output
    output logic            txReady,        // Byte taken
    output logic            remoteMode,     // Instrument in remote
    output logic            busActive,      // Bus interface selected
    output logic            listening,      // Addressed to listen
    output logic            talking,        // Addressed to talk
    output logic            pollEnabled     // Poll response configured
);
    // Plot counter is 16 bits wide
    if (PLOT_LIMIT < 2 || PLOT_LIMIT > 65535) begin : g_badLimit
        $error("gpibpp_dev_end: PLOT_LIMIT out of range");
    end

    typedef struct packed {
        logic       strapDone;          // Strap already sampled
        logic       active;             // Bus interface selected
        logic       remote;             // Remote state
        logic       listen;             // Listener addressed
        logic       talk;               // Talker addressed
        logic       ppcPend;            // PPC seen, awaiting secondary
        logic       ppEn;               // Poll response enabled
        logic       ppSense;            // Sense bit
        logic [2:0] ppLine;             // Line field
        logic [7:0] cByte;              // Character to user
        logic       cValid;             // Character pulse
        logic       cEnd;               // Command end pulse
        gpibpp_pkg::gpibpp_txph_t ph;   // Talker phase
        logic       dav;                // Byte offered on bus
        logic       eoi;                // End marker on bus
        logic [7:0] dio;                // Data lines
        logic [7:0] oeN;                // Line enables, low drives
        logic [15:0] plotCnt;           // Plot bytes so far
    } gpibpp_dstate_t;

    gpibpp_dstate_t s;          // Registered state
    gpibpp_dstate_t next_s;     // Next state
    logic           rxTake;     // Byte taken from controller
    logic           txLoad;     // User byte taken
    logic           plotEnd;    // Current plot byte is final
    logic [7:0]     rx;         // Byte from controller

    assign rx      = bus.ctlDio;
    // Accept commands whenever the interface is selected, data only when listening
    assign bus.devRfd = s.active && (bus.atn || s.listen);
    assign rxTake  = bus.ctlDav && bus.devRfd;
    // Talk only when addressed and attention released
    assign txLoad  = s.talk && !bus.atn && !s.dav && (s.ph == gpibpp_pkg::TX_DATA) && txValid;
    // Force the end at the size cap as well
    assign plotEnd = txLast || (s.plotCnt == 16'(PLOT_LIMIT - 1));

    always_comb begin
        next_s = s;
        next_s.cValid = 1'b0;
        next_s.cEnd   = 1'b0;
        // Strap read once after reset
        if (!s.strapDone) begin
            next_s.strapDone = 1'b1;
            next_s.active    = (addrSwitch == gpibpp_pkg::GPIB_STRAP);
        end
        // Receive side
        if (rxTake) begin
            if (bus.atn) begin
                // Any primary except PPC ends configuration mode
                if (rx[6:5] != gpibpp_pkg::SEC_GRP)
                    next_s.ppcPend = 1'b0;
                if (rx == gpibpp_pkg::CMD_UNL) begin
                    next_s.listen = 1'b0;
                end else if (rx == gpibpp_pkg::CMD_UNT) begin
                    next_s.talk = 1'b0;
                end else if (rx[7:5] == gpibpp_pkg::LISTEN_GRP && rx[4:0] == gpibpp_pkg::DEV_ADDR) begin
                    next_s.listen = 1'b1;
                    if (bus.ren)
                        next_s.remote = 1'b1;
                end else if (rx[7:5] == gpibpp_pkg::TALK_GRP) begin
                    // Own talk address, another one untalks us
                    next_s.talk = (rx[4:0] == gpibpp_pkg::DEV_ADDR);
                end else if (rx == gpibpp_pkg::CMD_PPC && s.listen) begin
                    next_s.ppcPend = 1'b1;
                end else if (rx == gpibpp_pkg::CMD_PPU && s.listen) begin
                    next_s.ppEn    = 1'b0;
                    next_s.ppSense = 1'b0;
                    next_s.ppLine  = 3'h0;
                end else if (rx == gpibpp_pkg::CMD_GTL && s.listen) begin
                    next_s.remote = 1'b0;
                end else if (s.ppcPend && rx[7:4] == gpibpp_pkg::PPE_TAG) begin
                    // Configuration complete without UNT/UNL
                    next_s.ppEn    = 1'b1;
                    next_s.ppSense = rx[gpibpp_pkg::PP_SENSE_BIT];
                    next_s.ppLine  = rx[2:0];
                end else if (s.ppcPend && rx[7:4] == gpibpp_pkg::PPD_TAG) begin
                    next_s.ppEn = 1'b0;
                end
            end else begin
                // Message bytes: split at semicolon, end at EOI
                if (rx == gpibpp_pkg::CHR_SEMI) begin
                    next_s.cEnd = 1'b1;
                end else begin
                    next_s.cByte  = rx;
                    next_s.cValid = 1'b1;
                end
                if (bus.ctlEoi)
                    next_s.cEnd = 1'b1;
            end
        end
        // Talker side: byte handed over when controller ready
        if (s.dav && (bus.ctlRfd || bus.atn))
            next_s.dav = 1'b0;
        if (txLoad) begin
            next_s.dio = txData;
            next_s.dav = 1'b1;
            if (txPlot) begin
                next_s.eoi     = plotEnd;
                next_s.plotCnt = plotEnd ? 16'h0000 : s.plotCnt + 16'h0001;
            end else begin
                next_s.eoi = 1'b0;
                if (txLast)
                    next_s.ph = gpibpp_pkg::TX_CR;
            end
        end else if (s.talk && !bus.atn && !s.dav && s.ph != gpibpp_pkg::TX_DATA) begin
            // Reply terminator, EOI on the line feed
            next_s.dav = 1'b1;
            if (s.ph == gpibpp_pkg::TX_CR) begin
                next_s.dio = gpibpp_pkg::CHR_CR;
                next_s.eoi = 1'b0;
                next_s.ph  = gpibpp_pkg::TX_LF;
            end else begin
                next_s.dio = gpibpp_pkg::CHR_LF;
                next_s.eoi = 1'b1;
                next_s.ph  = gpibpp_pkg::TX_DATA;
            end
        end
        // Clear overrides addressing, remote release overrides going remote
        if (bus.ifc) begin
            next_s.listen  = 1'b0;
            next_s.talk    = 1'b0;
            next_s.ppcPend = 1'b0;
        end
        if (!bus.ren)
            next_s.remote = 1'b0;
        // Line enables: whole byte while talking, one line in a poll
        next_s.oeN = 8'hFF;
        if (next_s.dav) begin
            next_s.oeN = 8'h00;
        end else if (bus.atn && bus.ctlEoi && s.ppEn && s.ppSense == srq) begin
            next_s.dio = 8'h01 << s.ppLine;
            next_s.oeN = ~(8'h01 << s.ppLine);
        end
        // An unselected interface never drives anything
        if (!s.active) begin
            next_s.dav    = 1'b0;
            next_s.oeN    = 8'hFF;
            next_s.listen = 1'b0;
            next_s.talk   = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            s     <= '0;
            s.oeN <= 8'hFF;
            s.ph  <= gpibpp_pkg::TX_DATA;
        end else begin
            s <= next_s;
        end
    end

    assign bus.devDio    = s.dio;
    assign bus.devDioOeN = s.oeN;
    assign bus.devEoi    = s.eoi;
    assign bus.devDav    = s.dav;
    assign cmdByte       = s.cByte;
    assign cmdValid      = s.cValid;
    assign cmdEnd        = s.cEnd;
    assign txReady       = txLoad;
    assign remoteMode    = s.remote;
    assign busActive     = s.active;
    assign listening     = s.listen;
    assign talking       = s.talk;
    assign pollEnabled   = s.ppEn;
endmodule

// *** gpibpp_pkg.sv ***
package gpibpp_pkg;
    // Strap value that selects the bus interface at power-up
    localparam logic [4:0] GPIB_STRAP  = 5'h04;
    // Bus address that the instrument answers to
    localparam logic [4:0] DEV_ADDR    = 5'h04;
    // Interface command bytes, sent with attention asserted
    localparam logic [7:0] CMD_GTL     = 8'h01;
    localparam logic [7:0] CMD_PPC     = 8'h05;
    localparam logic [7:0] CMD_PPU     = 8'h15;
    localparam logic [7:0] CMD_UNL     = 8'h3F;
    localparam logic [7:0] CMD_UNT     = 8'h5F;
    localparam logic [2:0] LISTEN_GRP  = 3'h1;    // Upper bits of a listen address
    localparam logic [2:0] TALK_GRP    = 3'h2;    // Upper bits of a talk address
    localparam logic [3:0] PPE_TAG     = 4'h6;    // Upper nibble of the enable byte
    localparam logic [3:0] PPD_TAG     = 4'h7;    // Upper nibble of the disable byte
    localparam logic [1:0] SEC_GRP     = 2'h3;    // Secondary byte group
    localparam int         PP_SENSE_BIT = 3;      // Sense bit position in enable byte
    // Message characters
    localparam logic [7:0] CHR_SEMI    = 8'h3B;
    localparam logic [7:0] CHR_CR      = 8'h0D;
    localparam logic [7:0] CHR_LF      = 8'h0A;
    // Largest plot output
    localparam int         PLOT_KBYTES = 50;
    localparam int         PLOT_MAX    = PLOT_KBYTES * 1024;
    // Timing
    localparam int         CLK_PERIOD_NS = 10;
    localparam int         PP_TIME_NS    = 200;   // Least poll identify time
    localparam int         IFC_TIME_NS   = 1000;  // Least clear pulse
    localparam int         PP_CYCLES  = (PP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         IFC_CYCLES = (IFC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Controller operations
    typedef enum logic [2:0] {
        OP_CMD, OP_DATA, OP_READ, OP_REN_ON, OP_REN_OFF, OP_POLL, OP_IFC
    } gpibpp_op_t;

    // Talker output phase of the instrument
    typedef enum logic [1:0] {TX_DATA, TX_CR, TX_LF} gpibpp_txph_t;

    // Controller sequencer state
    typedef enum logic [2:0] {C_IDLE, C_SEND, C_READ, C_POLL, C_IFC} gpibpp_cst_t;
endpackage

// *** gpibpp_bus_if.sv ***
`timescale 1ns/1ns
interface gpibpp_bus_if;
    logic       ren;        // Remote enable
    logic       atn;        // Attention: bytes are interface commands
    logic       ifc;        // Interface clear
    logic [7:0] ctlDio;     // Controller data lines
    logic       ctlEoi;     // End marker, or identify with atn
    logic       ctlDav;     // Controller byte valid
    logic       ctlRfd;     // Controller ready for a byte
    logic [7:0] devDio;     // Instrument data lines
    logic [7:0] devDioOeN;  // Instrument line enables, low drives
    logic       devEoi;     // Instrument end marker
    logic       devDav;     // Instrument byte valid
    logic       devRfd;     // Instrument ready for a byte

    modport dev (input ren, atn, ifc, ctlDio, ctlEoi, ctlDav, ctlRfd,
                 output devDio, devDioOeN, devEoi, devDav, devRfd);
    modport ctl (output ren, atn, ifc, ctlDio, ctlEoi, ctlDav, ctlRfd,
                 input devDio, devDioOeN, devEoi, devDav, devRfd);
endinterface

// *** gpibpp_ctl_end.sv ***
`timescale 1ns/1ns
module gpibpp_ctl_end #(
    parameter int PP_CNT  = gpibpp_pkg::PP_CYCLES,   // Poll identify length
    parameter int IFC_CNT = gpibpp_pkg::IFC_CYCLES   // Clear pulse length
) (
    input  wire logic               clk,        // 100 MHz clock
    input  wire logic               srst,       // Synchronous reset
    gpibpp_bus_if.ctl               bus,        // Bus towards instrument
    input  wire gpibpp_pkg::gpibpp_op_t cmdOp,  // Requested operation
    input  wire logic [7:0]         cmdData,    // Byte to send
    input  wire logic               cmdEoi,     // Mark byte as final
    input  wire logic               cmdValid,   // Operation request
    output logic                    cmdReady,   // Sequencer idle
    output logic [7:0]              rspData,    // Byte read or poll lines
    output logic                    rspEoi,     // End marker of byte read
    output logic                    rspValid    // Operation done pulse
);
    // Counts must fit the 8-bit timer
    if (PP_CNT < 1 || PP_CNT > 255 || IFC_CNT < 1 || IFC_CNT > 255) begin : g_badCnt
        $error("gpibpp_ctl_end: counts out of range");
    end

    typedef struct packed {
        gpibpp_pkg::gpibpp_cst_t st;    // Sequencer state
        logic       ren;                // Remote enable level
        logic       atn;                // Attention level
        logic       ifc;                // Clear level
        logic       eoi;                // End or identify level
        logic       dav;                // Byte offered
        logic       rfd;                // Ready to take
        logic [7:0] dio;                // Byte on the lines
        logic [7:0] cnt;                // Timer
        logic [7:0] rData;              // Answer byte
        logic       rEoi;               // Answer end marker
        logic       rValid;             // Done pulse
    } gpibpp_cstate_t;

    gpibpp_cstate_t s;          // Registered state
    gpibpp_cstate_t next_s;     // Next state

    // Sequencer: one operation at a time
    always_comb begin
        next_s = s;
        next_s.rValid = 1'b0;
        unique case (s.st)
            gpibpp_pkg::C_IDLE: begin
                if (cmdValid) begin
                    unique case (cmdOp)
                        gpibpp_pkg::OP_CMD: begin
                            // Addressing, PPC, enable byte, UNT/UNL in caller order
                            next_s.atn = 1'b1;
                            next_s.eoi = 1'b0;
                            next_s.dio = cmdData;
                            next_s.dav = 1'b1;
                            next_s.st  = gpibpp_pkg::C_SEND;
                        end
                        gpibpp_pkg::OP_DATA: begin
                            // Caller flags the last character
                            next_s.atn = 1'b0;
                            next_s.eoi = cmdEoi;
                            next_s.dio = cmdData;
                            next_s.dav = 1'b1;
                            next_s.st  = gpibpp_pkg::C_SEND;
                        end
                        gpibpp_pkg::OP_READ: begin
                            // Instrument talks only with attention released
                            next_s.atn = 1'b0;
                            next_s.eoi = 1'b0;
                            next_s.rfd = 1'b1;
                            next_s.st  = gpibpp_pkg::C_READ;
                        end
                        gpibpp_pkg::OP_REN_ON: begin
                            next_s.ren    = 1'b1;
                            next_s.rValid = 1'b1;
                        end
                        gpibpp_pkg::OP_REN_OFF: begin
                            // Releasing remote returns the instrument to local
                            next_s.ren    = 1'b0;
                            next_s.rValid = 1'b1;
                        end
                        gpibpp_pkg::OP_POLL: begin
                            next_s.atn = 1'b1;
                            next_s.eoi = 1'b1;
                            next_s.cnt = 8'(PP_CNT);
                            next_s.st  = gpibpp_pkg::C_POLL;
                        end
                        gpibpp_pkg::OP_IFC: begin
                            next_s.ifc = 1'b1;
                            next_s.cnt = 8'(IFC_CNT);
                            next_s.st  = gpibpp_pkg::C_IFC;
                        end
                        default: next_s.rValid = 1'b1;  // Unused code, done at once
                    endcase
                end
            end
            gpibpp_pkg::C_SEND: begin
                // Byte taken when instrument ready
                if (bus.devRfd) begin
                    next_s.dav    = 1'b0;
                    next_s.eoi    = 1'b0;
                    next_s.rValid = 1'b1;
                    next_s.st     = gpibpp_pkg::C_IDLE;
                end
            end
            gpibpp_pkg::C_READ: begin
                if (bus.devDav) begin
                    next_s.rfd    = 1'b0;
                    next_s.rData  = bus.devDio;
                    next_s.rEoi   = bus.devEoi;
                    next_s.rValid = 1'b1;
                    next_s.st     = gpibpp_pkg::C_IDLE;
                end
            end
            gpibpp_pkg::C_POLL: begin
                next_s.cnt = s.cnt - 8'h01;
                if (s.cnt == 8'h01) begin
                    // Only driven lines count as true
                    next_s.rData  = bus.devDio & ~bus.devDioOeN;
                    next_s.rEoi   = 1'b0;
                    next_s.eoi    = 1'b0;
                    next_s.rValid = 1'b1;
                    next_s.st     = gpibpp_pkg::C_IDLE;
                end
            end
            gpibpp_pkg::C_IFC: begin
                next_s.cnt = s.cnt - 8'h01;
                if (s.cnt == 8'h01) begin
                    next_s.ifc    = 1'b0;
                    next_s.rValid = 1'b1;
                    next_s.st     = gpibpp_pkg::C_IDLE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            s    <= '0;
            s.st <= gpibpp_pkg::C_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign bus.ren    = s.ren;
    assign bus.atn    = s.atn;
    assign bus.ifc    = s.ifc;
    assign bus.ctlDio = s.dio;
    assign bus.ctlEoi = s.eoi;
    assign bus.ctlDav = s.dav;
    assign bus.ctlRfd = s.rfd;
    assign cmdReady   = (s.st == gpibpp_pkg::C_IDLE);
    assign rspData    = s.rData;
    assign rspEoi     = s.rEoi;
    assign rspValid   = s.rValid;
endmodule

// *** gpibpp_bus_chk.sv ***
`timescale 1ns/1ns
module gpibpp_bus_chk (
    input wire logic       clk,        // Bus clock
    input wire logic       srst,       // Sync reset
    input wire logic       atn,        // Attention
    input wire logic [7:0] ctlDio,     // Controller byte
    input wire logic       ctlEoi,     // End or identify
    input wire logic       ctlDav,     // Controller valid
    input wire logic       ctlRfd,     // Controller ready
    input wire logic [7:0] devDio,     // Device byte
    input wire logic [7:0] devDioOeN,  // Device enables, low drives
    input wire logic       devEoi,     // Device end marker
    input wire logic       devDav,     // Device valid
    input wire logic       devRfd      // Device ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Two cycles of identify, so the registered answer has settled
    sequence s_pollId; (atn && ctlEoi && !ctlDav) [*2]; endsequence
    // Two cycles of plain command phase
    sequence s_cmdPhase; (atn && !ctlEoi) [*2]; endsequence
    a_ctl_dav_drop: assert property (ctlDav && devRfd |=> !ctlDav)
        else $error("controller byte held after it was taken");
    a_ctl_dav_hold: assert property (ctlDav && !devRfd |=> ctlDav && $stable(ctlDio) && $stable(atn))
        else $error("controller byte changed before it was taken");
    a_dev_dav_drop: assert property (devDav && ctlRfd |=> !devDav)
        else $error("device byte held after it was taken");
    a_talk_hold: assert property ((devDav && !ctlRfd && !atn) ##1 !atn |-> devDav && $stable(devDio) && $stable(devEoi))
        else $error("device byte changed while waiting");
    a_talk_drives: assert property (devDav && !atn |-> devDioOeN == 8'h00)
        else $error("talk byte offered without driving lines");
    a_cmd_quiet: assert property (s_cmdPhase |-> devDioOeN == 8'hFF)
        else $error("device drives lines in command phase");
    a_poll_onehot: assert property (s_pollId |-> $onehot0(~devDioOeN))
        else $error("poll answer on more than one line");
    a_poll_release: assert property ((atn && ctlEoi && !ctlDav) ##1 !ctlEoi |-> ##[1:2] devDioOeN == 8'hFF)
        else $error("poll line not released after identify");
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
    logic clk = 0, srst = 1, cmdEoi = 0, cmdValid = 0, srq = 0, txValid = 0, txLast = 0, txPlot = 0, tkn = 0, sn;
    logic [7:0] cmdData = 0, txData = 0, rspData, cmdByte;
    logic [4:0] addrSwitch = 5'h04;          // Strap selects the bus
    logic cmdReady, rspEoi, rspValid, rxValid, cmdEnd, txReady, remoteMode, busActive, listening, talking, pollEnabled;
    gpibpp_pkg::gpibpp_op_t cmdOp = gpibpp_pkg::OP_CMD;
    int fail_count = 0, num_checks = 0, nEnd = 0, n, r;
    logic [7:0] rxQ[$], txQ[$], expQ[$];
    string s = "TD 1MS;TD ?";
    gpibpp_bus_if bus ();
    gpibpp_ctl_end #(.PP_CNT(4), .IFC_CNT(4)) gpibpp_ctl_end_i (.clk(clk), .srst(srst), .bus(bus), .cmdOp(cmdOp),
        .cmdData(cmdData), .cmdEoi(cmdEoi), .cmdValid(cmdValid), .cmdReady(cmdReady), .rspData(rspData),
        .rspEoi(rspEoi), .rspValid(rspValid));
    gpibpp_dev_end #(.PLOT_LIMIT(16)) gpibpp_dev_end_i (.clk(clk), .srst(srst), .bus(bus), .addrSwitch(addrSwitch),
        .srq(srq), .cmdByte(cmdByte), .cmdValid(rxValid), .cmdEnd(cmdEnd), .txData(txData), .txValid(txValid),
        .txLast(txLast), .txPlot(txPlot), .txReady(txReady), .remoteMode(remoteMode), .busActive(busActive),
        .listening(listening), .talking(talking), .pollEnabled(pollEnabled));
    gpibpp_bus_chk gpibpp_bus_chk_i (.clk(clk), .srst(srst), .atn(bus.atn), .ctlDio(bus.ctlDio), .ctlEoi(bus.ctlEoi),
        .ctlDav(bus.ctlDav), .ctlRfd(bus.ctlRfd), .devDio(bus.devDio), .devDioOeN(bus.devDioOeN),
        .devEoi(bus.devEoi), .devDav(bus.devDav), .devRfd(bus.devRfd));
    always #5 clk = ~clk;
    // Collect received characters; pulses stand a whole cycle
    always @(negedge clk) begin
        if (rxValid) rxQ.push_back(cmdByte);
        nEnd += int'(cmdEnd);
    end
    // Offer reply bytes; taken flag sampled late, once txReady settles
    always @(negedge clk) begin
        if (tkn) void'(txQ.pop_front());
        txValid = txQ.size() > 0;
        txData = txValid ? txQ[0] : 8'h00;
        txLast = txQ.size() == 1;
        #4 tkn = txValid && txReady;
    end
    task automatic chk8(input logic [7:0] g, e);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // One controller operation, bounded wait for its done pulse
    task automatic op(input gpibpp_pkg::gpibpp_op_t o, input logic [7:0] d, input logic e = 1'b0);
        @(negedge clk);
        cmdOp = o;
        cmdData = d;
        cmdEoi = e;
        cmdValid = 1;
        @(negedge clk);
        cmdValid = 0;
        for (int i = 0; i < 300 && rspValid !== 1'b1; i++) @(negedge clk);
        if (rspValid !== 1'b1) chk8(8'h01, 8'h00);
    endtask
    task automatic send(input logic [7:0] b, input logic last);
        op(gpibpp_pkg::OP_DATA, b, last);
        if (b != gpibpp_pkg::CHR_SEMI) expQ.push_back(b);
    endtask
    task automatic rd(input logic [7:0] e, input logic eo);
        op(gpibpp_pkg::OP_READ, 8'h00);
        chk8(rspData, e);
        chk8({7'h00, rspEoi}, {7'h00, eo});
    endtask
    task automatic ppSet(input logic [7:0] b);
        op(gpibpp_pkg::OP_CMD, 8'h24);
        op(gpibpp_pkg::OP_CMD, gpibpp_pkg::CMD_PPC);
        op(gpibpp_pkg::OP_CMD, b);
    endtask
    // Expected poll pattern: line answers when sense matches request
    function automatic logic [7:0] ppExp(int l, logic se, logic q);
        return (se == q) ? 8'h01 << l : 8'h00;
    endfunction
    initial begin
        #200000 fail_count++;
        give_verdict();
    end
    initial begin
        r = $urandom(32'hf3dd_0770);
        repeat (16) @(negedge clk);
        srst = 0;
        repeat (2) @(negedge clk);
        chk8({7'h00, busActive}, 8'h01);
        op(gpibpp_pkg::OP_REN_ON, 8'h00);
        op(gpibpp_pkg::OP_CMD, 8'h24);
        chk8({7'h00, remoteMode}, 8'h01);
        chk8({6'h00, listening, talking}, 8'h02);
        foreach (s[i]) send(s[i], i == s.len() - 1);
        repeat (3) begin
            n = 1 + $urandom % 6;
            for (int i = 0; i < n; i++) send(8'h41 + 8'($urandom % 26), i == n - 1);
        end
        repeat (3) @(negedge clk);
        chk8(8'(nEnd), 8'h05);
        chk8(8'(rxQ.size()), 8'(expQ.size()));
        foreach (expQ[i]) chk8(rxQ[i], expQ[i]);
        repeat (4) txQ.push_back(8'h30 + 8'($urandom % 10));
        expQ = txQ;
        expQ.push_back(gpibpp_pkg::CHR_CR);
        expQ.push_back(gpibpp_pkg::CHR_LF);
        op(gpibpp_pkg::OP_CMD, 8'h44);
        foreach (expQ[i]) rd(expQ[i], i == expQ.size() - 1);
        op(gpibpp_pkg::OP_CMD, gpibpp_pkg::CMD_UNT);
        txPlot = 1;
        repeat (20) txQ.push_back(8'($urandom));
        repeat (10) @(negedge clk);
        chk8(8'(txQ.size()), 8'h14);
        expQ = txQ;
        op(gpibpp_pkg::OP_CMD, 8'h44);
        foreach (expQ[i]) rd(expQ[i], i == 15 || i == 19);
        txPlot = 0;
        op(gpibpp_pkg::OP_POLL, 8'h00);
        chk8(rspData, 8'h00);
        for (int l = 0; l < 8; l++) begin
            sn = l[0];
            srq = 1'($urandom);
            ppSet({4'h6, sn, 3'(l)});
            op(gpibpp_pkg::OP_POLL, 8'h00);
            chk8(rspData, ppExp(l, sn, srq));
        end
        srq = 1;
        ppSet(8'h7B);
        op(gpibpp_pkg::OP_POLL, 8'h00);
        chk8(rspData, 8'h00);
        ppSet(8'h6A);
        op(gpibpp_pkg::OP_CMD, 8'h24);
        op(gpibpp_pkg::OP_CMD, gpibpp_pkg::CMD_PPU);
        chk8({7'h00, pollEnabled}, 8'h00);
        op(gpibpp_pkg::OP_POLL, 8'h00);
        chk8(rspData, 8'h00);
        op(gpibpp_pkg::OP_CMD, gpibpp_pkg::CMD_GTL);
        chk8({7'h00, remoteMode}, 8'h00);
        op(gpibpp_pkg::OP_CMD, 8'h24);
        op(gpibpp_pkg::OP_CMD, gpibpp_pkg::CMD_UNT);
        op(gpibpp_pkg::OP_CMD, gpibpp_pkg::CMD_UNL);
        chk8({6'h00, listening, talking}, 8'h00);
        op(gpibpp_pkg::OP_REN_OFF, 8'h00);
        // Remote drops a cycle after remote enable is released
        @(negedge clk);
        chk8({7'h00, remoteMode}, 8'h00);
        op(gpibpp_pkg::OP_CMD, 8'h24);
        op(gpibpp_pkg::OP_IFC, 8'h00);
        chk8({6'h00, listening, talking}, 8'h00);
        // Wrong strap: bus stays dead, a command is never taken
        srst = 1;
        addrSwitch = 5'h07;
        repeat (2) @(negedge clk);
        srst = 0;
        cmdOp = gpibpp_pkg::OP_CMD;
        cmdData = 8'h24;
        cmdValid = 1;
        @(negedge clk);
        cmdValid = 0;
        repeat (6) @(negedge clk);
        chk8({7'h00, busActive}, 8'h00);
        chk8({7'h00, cmdReady}, 8'h00);
        give_verdict();
    end
endmodule
